// [ntsc_pkg.sv]
// Constants and types for the network time stamp counter
`default_nettype none
package ntsc_pkg;

   // Width of the network time value
   localparam int NTSC_TIME_W = 16;
   // Network time after reset
   localparam logic [15:0] NTSC_TIME_RST = 16'h0000;
   // Prescaler divide counter after reset
   localparam logic [11:0] NTSC_DIV_RST = 12'h000;
   // Smallest prescaler ratio, selected by code 000
   localparam logic [12:0] NTSC_DIV_BASE = 13'h0020;
   // Trigger source code that latches time on the external trigger
   localparam logic [3:0] NTSC_TRIG_EXT_LATCH = 4'h6;
   // Flag selection code that routes the carry to the flag pin
   localparam logic [3:0] NTSC_FLAG_SEL_CARRY = 4'h2;
   // Master identifier meaning no master configured
   localparam logic [3:0] NTSC_ID_NONE = 4'h0;
   // Allowed difference, either sign, between master and local time
   localparam logic [15:0] NTSC_LOCK_WIN = 16'h0002;
   // Consecutive in-window master values needed to lock
   localparam logic [1:0] NTSC_LOCK_COUNT = 2'h3;
   // Carry style code that selects the clock form
   localparam logic NTSC_STYLE_CLOCK = 1'b1;

   // Configuration received from the network
   typedef struct packed {
      logic [3:0] master_node_id;            // Clock master node number
      logic [3:0] own_node_id;               // This node's number
      logic [2:0] time_prescale_select;      // Prescaler ratio code
      logic [3:0] carry_bit_select;          // Time bit driving the carry
      logic carry_output_style;              // 0 pulse, 1 clock
      logic [3:0] flag_output_select;        // Flag pin function
      logic [3:0] transmit_trigger_select;   // Transmit trigger source
      logic page_size_select;                // 1 = 64-byte pages, 0 = 128-byte
   } ntsc_cfg_type;

   // Time field of a received packet
   typedef struct packed {
      logic valid;                           // One-cycle packet strobe
      logic [3:0] src_id;                    // Sending node
      logic [15:0] time_val;                 // Last two bytes of the packet
   } ntsc_rx_type;

   // Carry output sequencer
   typedef enum logic [1:0] {
      NTSC_CARRY_HOLD = 2'b01,
      NTSC_CARRY_RUN = 2'b10
   } ntsc_carry_state_type;

endpackage : ntsc_pkg
`default_nettype wire

// [ntsc_top.sv]
// Network time counter with sync, lock detection, stamps and carry output
// Notes on behaviour
// RL1 - Keep 16-bit time, carried in last bytes
// RL2 - Master time syncs; others give receive stamp
// RL3 - Default transmit stamp is current time
// RL4 - Trigger code 6h sends externally latched time
// RL5 - Master id 1-15, or 1-7 with large pages
// RL6 - Sync needs config, then a master packet
// RL7 - Prescaler codes select ratios 32 to 4096
// RL8 - All synchronised nodes share one resolution
// RL9 - Realign on every master packet, any destination
// RL10 - Pin and status bit show lock state
// RL11 - Carry select picks time bit 0-15
// RL12 - Carry on flag pin; pulse or clock style
// RL13 - Carry pin high until start condition
// RL14 - Own or zero master: start on setup
// RL15 - Other master: start on its first packet
// RL16 - Exactly one clock master per network
// RL17 - Lock after three in-window values; else unlock
// RL18 - Sticky unlock bit; default 1; 0 if master
// RL19 - Carry pin low pulse, or toggling clock
// RL20 - Counter increments per tick and wraps
// RL21 - Master packet loads received time
`timescale 1ns/1ns
`default_nettype none
module ntsc_top
(
   input wire logic clk_i,                          // System clock, 100 MHz
   input wire logic rst_n_i,                        // Asynchronous reset, active low
   input wire ntsc_pkg::ntsc_cfg_type cfg_i,        // Network configuration
   input wire logic cfg_ready_i,                    // Master id and prescaler configured
   input wire logic init_setting_i,                 // Initial setting packet received
   input wire ntsc_pkg::ntsc_rx_type rx_i,          // Received packet time field
   input wire logic tx_start_i,                     // Packet transmission begins
   input wire logic ext_trig_i,                     // External trigger pulse
   input wire logic sync_lost_clear_i,              // Clear the sticky unlock bit
   output logic [15:0] network_time_o,              // Local network time
   output logic [15:0] tx_stamp_o,                  // Time for the outgoing packet
   output logic [15:0] rx_stamp_o,                  // Receive stamp from non-master
   output logic rx_stamp_valid_o,                   // Receive stamp updated
   output logic sync_lost_flag_o,                   // Unlock pin, follows state
   output logic sync_lost_status_o,                 // Sticky unlock status bit
   output logic time_carry_out_n_o                  // Carry on the flag pin
);
   import ntsc_pkg::*;

   // Last value of the prescaler divide counter for a select code
   function automatic logic [11:0] div_limit(input logic [2:0] sel);
      logic [12:0] ratio;
      ratio = NTSC_DIV_BASE << sel;
      return 12'(ratio - 13'h0001);
   endfunction : div_limit

   // True when two times differ by no more than the lock window
   function automatic logic in_window(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] diff;
      diff = a - b;
      return (diff <= NTSC_LOCK_WIN) || (diff >= 16'(16'h0000 - NTSC_LOCK_WIN));
   endfunction : in_window

   logic [11:0] div_q, div_d;                       // Prescaler counter
   logic [15:0] time_q, time_d;                     // Network time counter
   logic [1:0] good_q, good_d;                      // Consecutive in-window count
   logic locked_q, locked_d;                        // Locked to master
   logic lost_pin_q, lost_pin_d;                    // Unlock pin register
   logic status_q, status_d;                        // Sticky unlock bit
   logic [15:0] ext_q, ext_d;                       // Time latched at trigger
   logic [15:0] tx_q, tx_d;                         // Transmit stamp
   logic [15:0] rxs_q, rxs_d;                       // Receive stamp
   logic rxv_q, rxv_d;                              // Receive stamp strobe
   ntsc_carry_state_type cst_q, cst_d;              // Carry sequencer state
   logic cbit_q, cbit_d;                            // Selected bit, last cycle
   logic carry_n_q, carry_n_d;                      // Carry pin register
   logic tick;                                      // Prescaled time tick
   logic other_master;                              // Another node is master
   logic from_master;                               // Packet came from master
   logic sync_evt;                                  // Synchronising packet
   logic cbit;                                      // Selected time bit now
   logic [1:0] win_run_q, win_run_d;                // Checker count of good syncs

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Decode of the sender and the configuration
   always_comb
   begin
      other_master = (cfg_i.master_node_id != cfg_i.own_node_id)
                     && (cfg_i.master_node_id != NTSC_ID_NONE);
      from_master = rx_i.valid && (rx_i.src_id == cfg_i.master_node_id);
      // RL6 sync enable gate
      // RL9 any master packet
      sync_evt = from_master && other_master && cfg_ready_i;
      // RL7 ratio from code
      tick = (div_q == div_limit(cfg_i.time_prescale_select));
      cbit = time_q[cfg_i.carry_bit_select];
   end

   // Next prescaler and time values
   always_comb
   begin
      div_d = div_q + 12'h001;
      time_d = time_q;
      if (sync_evt)
      begin
         // RL21 load master time
         time_d = rx_i.time_val;
         div_d = NTSC_DIV_RST;
      end
      else if (tick)
      begin
         // RL20 count and wrap
         time_d = time_q + 16'h0001;
         div_d = NTSC_DIV_RST;
      end
   end

   // RL20 count per tick
   time_count_a: assert property (tick && !sync_evt // RL20
      |=> time_q == $past(time_q) + 16'h0001)
      else $error("time did not advance on tick");
   // RL7 divider bound
   div_bound_a: assert property (!tick && !sync_evt |=> time_q == $past(time_q)) // RL7
      else $error("time moved without tick");
   // RL21 sync load
   sync_load_a: assert property (sync_evt |=> time_q == $past(rx_i.time_val)) // RL21
      else $error("master time not loaded");

   // Next lock state, unlock pin and sticky bit
   always_comb
   begin
      good_d = good_q;
      locked_d = locked_q;
      if (sync_evt)
      begin
         // RL17 window and count
         if (in_window(rx_i.time_val, time_q))
         begin
            good_d = (good_q == NTSC_LOCK_COUNT) ? good_q : good_q + 2'h1;
            locked_d = locked_q || (good_d == NTSC_LOCK_COUNT);
         end
         else
         begin
            good_d = 2'h0;
            locked_d = 1'b0;
         end
      end
      // RL10 pin follows lock
      lost_pin_d = other_master && !locked_d;
      // RL18 sticky, set beats clear
      status_d = other_master && (!locked_d || (status_q && !sync_lost_clear_i));
   end

   // Checker count of consecutive in-window master values, saturating
   always_comb
   begin
      win_run_d = !sync_evt ? win_run_q : !in_window(rx_i.time_val, time_q) ? 2'h0
                  : (win_run_q == NTSC_LOCK_COUNT) ? win_run_q : win_run_q + 2'h1;
   end

   // Master value inside the lock window
   sequence good_sync_s;
      sync_evt && in_window(rx_i.time_val, time_q);
   endsequence

   // RL17 lock after three
   lock_three_a: assert property (good_sync_s ##0 (win_run_q >= 2'h2) |=> !lost_pin_q) // RL17
      else $error("no lock after three good values");
   // RL17 unlock on miss
   unlock_miss_a: assert property (sync_evt && !in_window(rx_i.time_val, time_q) // RL17
      |=> lost_pin_q && status_q)
      else $error("unlock not flagged");
   // RL18 master reads zero
   master_zero_a: assert property (!other_master && $stable(cfg_i) // RL18
      |=> !status_q && !lost_pin_q)
      else $error("unlock shown on master node");

   // Next transmit and receive stamps
   always_comb
   begin
      ext_d = ext_trig_i ? time_q : ext_q;
      tx_d = tx_q;
      rxs_d = rxs_q;
      rxv_d = 1'b0;
      if (tx_start_i)
      begin
         // RL4 latched trigger time
         // RL3 otherwise send time
         tx_d = (cfg_i.transmit_trigger_select == NTSC_TRIG_EXT_LATCH) ? ext_q : time_q;
      end
      // RL2 non-master gives stamp
      if (rx_i.valid && !(rx_i.src_id == cfg_i.master_node_id))
      begin
         rxs_d = rx_i.time_val;
         rxv_d = 1'b1;
      end
   end

   // RL4 trigger stamp
   trig_stamp_a: assert property (tx_start_i // RL4
      && cfg_i.transmit_trigger_select == NTSC_TRIG_EXT_LATCH |=> tx_q == $past(ext_q))
      else $error("latched trigger time not sent");
   // RL3 default stamp
   send_stamp_a: assert property (tx_start_i // RL3
      && cfg_i.transmit_trigger_select != NTSC_TRIG_EXT_LATCH |=> tx_q == $past(time_q))
      else $error("send time not stamped");
   // RL2 receive stamp
   rx_stamp_a: assert property (rx_i.valid && rx_i.src_id != cfg_i.master_node_id // RL2
      |=> rxv_q && rxs_q == $past(rx_i.time_val))
      else $error("receive stamp missing");

   // Next carry sequencer and pin
   always_comb
   begin
      cst_d = cst_q;
      cbit_d = cbit;
      carry_n_d = 1'b1;
      case (cst_q)
         NTSC_CARRY_HOLD:
         begin
            // RL14 own or no master
            // RL15 other master packet
            if (other_master ? from_master : init_setting_i)
            begin
               cst_d = NTSC_CARRY_RUN;
            end
         end
         NTSC_CARRY_RUN:
         begin
            // RL12 routed to flag pin
            // RL19 clock or low pulse
            // RL11 selected time bit
            if (cfg_i.flag_output_select == NTSC_FLAG_SEL_CARRY)
            begin
               carry_n_d = (cfg_i.carry_output_style == NTSC_STYLE_CLOCK) ? !cbit
                  : !(cbit_q && !cbit);
            end
         end
         default:
         begin
            cst_d = NTSC_CARRY_HOLD;
         end
      endcase
   end

   // RL13 carry held high
   carry_hold_a: assert property (cst_q == NTSC_CARRY_HOLD |=> carry_n_q) // RL13
      else $error("carry active before start");

   // State registers
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_q <= NTSC_DIV_RST;
         time_q <= NTSC_TIME_RST;
         good_q <= 2'h0;
         locked_q <= 1'b0;
         lost_pin_q <= 1'b1;
         status_q <= 1'b1;
         ext_q <= NTSC_TIME_RST;
         tx_q <= NTSC_TIME_RST;
         rxs_q <= NTSC_TIME_RST;
         rxv_q <= 1'b0;
         cst_q <= NTSC_CARRY_HOLD;
         cbit_q <= 1'b0;
         win_run_q <= 2'h0;
         // RL13 high out of reset
         carry_n_q <= 1'b1;
      end
      else
      begin
         div_q <= div_d;
         time_q <= time_d;
         good_q <= good_d;
         locked_q <= locked_d;
         lost_pin_q <= lost_pin_d;
         status_q <= status_d;
         ext_q <= ext_d;
         tx_q <= tx_d;
         rxs_q <= rxs_d;
         rxv_q <= rxv_d;
         cst_q <= cst_d;
         cbit_q <= cbit_d;
         win_run_q <= win_run_d;
         carry_n_q <= carry_n_d;
      end
   end

   // Outputs straight from registers
   // RL1 time value out
   assign network_time_o = time_q;
   assign tx_stamp_o = tx_q;
   assign rx_stamp_o = rxs_q;
   assign rx_stamp_valid_o = rxv_q;
   assign sync_lost_flag_o = lost_pin_q;
   assign sync_lost_status_o = status_q;
   assign time_carry_out_n_o = carry_n_q;
endmodule : ntsc_top
`default_nettype wire

// [ntsc_node_model.sv]
// Behavioural model of the other network nodes, clock master among them
`timescale 1ns/1ns
`default_nettype none
module ntsc_node_model
   import ntsc_pkg::*;
(
   input wire logic clk_i,                  // System clock
   output var ntsc_pkg::ntsc_rx_type rx_o   // Time field of a packet
);
   // Packet field idles empty until the first packet
   initial rx_o = '0;

   // time in last bytes, one strobe
   // sender id given per packet, one master
   task automatic send(input logic [3:0] src, input logic [15:0] tval);
      @(posedge clk_i);
      rx_o <= '{valid: 1'b1, src_id: src, time_val: tval};
      @(posedge clk_i);
      // Released fields show the inverse, never the last value
      rx_o <= '{valid: 1'b0, src_id: ~src, time_val: ~tval};
   endtask : send
endmodule : ntsc_node_model
`default_nettype wire

// [ntsc_top_test.sv]
// Self-checking testbench for the network time stamp counter
`timescale 1ns/1ns
`default_nettype none
module ntsc_top_test;
   import ntsc_pkg::*;
   logic clk_i = 1'b0;         // System clock
   logic rst_n_i = 1'b0;       // Reset, active low
   ntsc_cfg_type cfg = '0;     // Configuration levels
   logic cfg_ready = 1'b0;     // Sync enable
   logic [3:0] pls = 4'h0;     // Clear, transmit, trigger, initial setting
   ntsc_rx_type rx;            // Packet from the model
   logic [15:0] ntime, txs, rxs; // Time and stamps
   logic rxv, lost, lost_st, carry_n; // Flags and pin
   int num_errors = 0;         // Mismatches
   int comparisons = 0;        // Compares made

   // Clock at 100 MHz
   always #5 clk_i = ~clk_i;

   ntsc_top i_ntsc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
      .cfg_ready_i(cfg_ready), .init_setting_i(pls[0]), .rx_i(rx), .tx_start_i(pls[2]),
      .ext_trig_i(pls[1]), .sync_lost_clear_i(pls[3]), .network_time_o(ntime),
      .tx_stamp_o(txs), .rx_stamp_o(rxs), .rx_stamp_valid_o(rxv), .sync_lost_flag_o(lost),
      .sync_lost_status_o(lost_st), .time_carry_out_n_o(carry_n));
   ntsc_node_model i_ntsc_node_model (.clk_i(clk_i), .rx_o(rx));

   // Compares one value and counts it
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One-cycle pulse on a strobe input
   task automatic pulse(input int idx);
      @(posedge clk_i);
      pls[idx] <= 1'b1;
      @(posedge clk_i);
      pls[idx] <= 1'b0;
      #1;
   endtask : pulse

   // Holds reset four edges and checks the reset state
   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      check("reset time", ntime, 16'h0000);
      check("reset lost", lost_st, 1'b1);
      check("reset carry", carry_n, 1'b1);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
   endtask : do_reset

   // Waits for the next time change; checks step and period
   task automatic wait_tick(input int per);
      logic [15:0] t0;
      int n;
      t0 = ntime;
      n = 0;
      while (ntime === t0 && n < 10000)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check("tick step", ntime, t0 + 16'h0001);
      if (per != 0)
         check("tick period", n[15:0], per[15:0]);
   endtask : wait_tick

   // Every prescaler code and its ratio
   task automatic t_prescale();
      for (int c = 0; c < 8; c++)
      begin
         @(posedge clk_i);
         cfg.time_prescale_select <= c[2:0];
         #1;
         wait_tick(0);
         wait_tick(32 << c);
      end
      @(posedge clk_i);
      cfg.time_prescale_select <= 3'h0;
      #1;
      wait_tick(0);
      $display("prescale done");
   endtask : t_prescale

   // Carry pin: 0 pulse, 1 clock, 2 flag routed elsewhere, 3 held
   task automatic t_carry(input int mode);
      logic b1;
      logic b2;
      logic want;
      b2 = ntime[2];
      @(posedge clk_i);
      cfg.carry_output_style <= (mode == 1);
      cfg.flag_output_select <= (mode == 2) ? 4'h0 : NTSC_FLAG_SEL_CARRY;
      #1;
      b1 = ntime[2];
      repeat (600)
      begin
         @(posedge clk_i);
         #1;
         want = (mode >= 2) ? 1'b1 : (mode == 1) ? ~b1 : ~(b2 & ~b1);
         check("carry pin", carry_n, want);
         b2 = b1;
         b1 = ntime[2];
      end
      $display("carry mode %0d done", mode);
   endtask : t_carry

   // Stamp from a node that is not master
   task automatic t_rx();
      i_ntsc_node_model.send(4'h5, 16'h1234);
      #1;
      check("rx stamp", rxs, 16'h1234);
      check("rx valid", rxv, 1'b1);
      check("no sync", ntime !== 16'h1234, 1'b1);
      @(posedge clk_i);
      #1;
      check("rx valid drop", rxv, 1'b0);
      $display("rx stamp done");
   endtask : t_rx

   // Sync enable, lock, sticky unlock, load and wrap
   task automatic t_sync();
      logic [15:0] t0;
      i_ntsc_node_model.send(4'h3, 16'h5000);
      #1;
      check("sync off", ntime !== 16'h5000, 1'b1);
      @(posedge clk_i);
      cfg_ready <= 1'b1;
      #1;
      for (int k = 0; k < 3; k++)
      begin
         t0 = ntime + 16'h0001;
         i_ntsc_node_model.send(4'h3, t0);
         #1;
         check("sync load", ntime, t0);
         check("lock flag", lost, k != 2);
         check("lock status", lost_st, 1'b1);
      end
      pulse(3);
      check("status cleared", lost_st, 1'b0);
      i_ntsc_node_model.send(4'h3, 16'h5000);
      #1;
      check("resync load", ntime, 16'h5000);
      check("unlock flag", lost, 1'b1);
      check("unlock status", lost_st, 1'b1);
      i_ntsc_node_model.send(4'h3, 16'hFFFF);
      #1;
      wait_tick(32);
      $display("sync done");
   endtask : t_sync

   // Transmit stamp for one trigger source code
   task automatic t_tx(input logic [3:0] trig);
      logic [15:0] t0;
      logic [15:0] t1;
      @(posedge clk_i);
      cfg.transmit_trigger_select <= trig;
      pls[1] <= 1'b1;
      #1;
      t0 = ntime;
      @(posedge clk_i);
      pls[1] <= 1'b0;
      repeat (40) @(posedge clk_i);
      pls[2] <= 1'b1;
      #1;
      t1 = ntime;
      @(posedge clk_i);
      pls[2] <= 1'b0;
      #1;
      check("tx stamp", txs, (trig == NTSC_TRIG_EXT_LATCH) ? t0 : t1);
      $display("tx stamp %0h done", trig);
   endtask : t_tx

   // Own node as master: after reset no unlock is shown
   task automatic t_own();
      @(posedge clk_i);
      cfg.master_node_id <= 4'h1;
      do_reset();
      repeat (2) @(posedge clk_i);
      #1;
      check("own status", lost_st, 1'b0);
      check("own flag", lost, 1'b0);
      $display("own master done");
   endtask : t_own

   // Prints counts and verdict, then ends the run
   task automatic final_report();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      // master 3, own 1, shared resolution
      cfg.master_node_id = 4'h3;
      cfg.own_node_id = 4'h1;
      cfg.carry_bit_select = 4'h2;
      cfg.carry_output_style = NTSC_STYLE_CLOCK;
      cfg.page_size_select = 1'b1;
      do_reset();
      t_prescale();
      t_carry(3);
      t_rx();
      t_sync();
      t_carry(1);
      t_carry(0);
      t_carry(2);
      for (int c = 0; c < 16; c++)
         t_tx(c[3:0]);
      t_own();
      t_carry(3);
      pulse(0);
      t_carry(1);
      final_report();
   end

   // Cuts a hang short; the tests need about 21000 cycles
   initial
   begin
      #600000;
      num_errors++;
      $display("[ERR] watchdog expected finish seen hang");
      final_report();
   end
endmodule : ntsc_top_test
`default_nettype wire
